//--- rtl/cax_defines.vh
// Constants for the execution slice: opcodes, register map, field layout.
// Included by every design file of the slice; holds definitions only.
`ifndef CAX_DEFINES_VH
`define CAX_DEFINES_VH

// ----------------------------------------------------------------------
// Operation codes presented by the decoder
// ----------------------------------------------------------------------
`define CAX_OP_W 3
`define CAX_OP_ADD_LITERAL_TO_POINTER 3'h0
`define CAX_OP_AND_IMM_ACC 3'h1
`define CAX_OP_ADD_IMM_ACC 3'h2
`define CAX_OP_AND_ACC_REG 3'h3
`define CAX_OP_ADD_ACC_REG 3'h4
`define CAX_OP_ADD_ACC_REG_WITH_CARRY 3'h5
`define CAX_OP_ARITH_SHIFT_RIGHT 3'h6
`define CAX_OP_BIT_CLEAR_REG 3'h7

// ----------------------------------------------------------------------
// Datapath widths and limits
// ----------------------------------------------------------------------
`define CAX_DATA_W 8
`define CAX_PTR_W 16
`define CAX_PTR_MASK 16'h0fff
`define CAX_FADDR_W 7
`define CAX_FILE_DEPTH 128
`define CAX_LIT6_W 6
`define CAX_DEST_ACC 1'b0
`define CAX_DEST_FILE 1'b1

// ----------------------------------------------------------------------
// Status register layout
// ----------------------------------------------------------------------
`define CAX_ST_CARRY 0
`define CAX_ST_NIBBLE_CARRY 1
`define CAX_ST_ZERO 2

// ----------------------------------------------------------------------
// APB register map (byte addresses, 12-bit decode)
// ----------------------------------------------------------------------
`define CAX_ADDR_W 12
`define CAX_REG_ACC 12'h000
`define CAX_REG_STATUS 12'h004
`define CAX_REG_PTR0 12'h008
`define CAX_REG_PTR1 12'h00c
`define CAX_REG_EXEC_COUNT 12'h010
`define CAX_FILE_BASE_HI 3'h1
`define CAX_ACC_RST 8'h00
`define CAX_PTR_RST 16'h0000

`endif

//--- rtl/cax_alu.v
// Combinational ALU of the execution slice: byte results and flag updates.
// Assumes the caller registers the outputs and supplies decoded operands.
`timescale 1ns/1ps
`default_nettype none
`include "cax_defines.vh"

module cax_alu (
   input wire [`CAX_OP_W-1:0] op_i,
   input wire [7:0] acc_i,
   input wire [7:0] freg_i,
   input wire [7:0] literal_i,
   input wire carry_i,
   input wire [2:0] bit_sel_i,
   output reg [7:0] result_o,
   output reg carry_o,
   output reg nibble_carry_o,
   output reg zero_o,
   output reg upd_carry_o,
   output reg upd_nibble_o,
   output reg upd_zero_o
);

   reg [7:0] add_a;
   reg [7:0] add_b;
   reg add_cin;
   reg [8:0] sum;
   reg [4:0] low_sum;

   always @* begin
      add_a = acc_i;
      add_b = freg_i;
      add_cin = 1'b0;
      result_o = acc_i;
      upd_carry_o = 1'b0;
      upd_nibble_o = 1'b0;
      upd_zero_o = 1'b0;
      carry_o = carry_i;
      case (op_i)
         `CAX_OP_AND_IMM_ACC: begin
            result_o = acc_i & literal_i;
            upd_zero_o = 1'b1;
         end
         `CAX_OP_ADD_IMM_ACC: begin
            add_b = literal_i;
            upd_carry_o = 1'b1;
            upd_nibble_o = 1'b1;
            upd_zero_o = 1'b1;
         end
         `CAX_OP_AND_ACC_REG: begin
            result_o = acc_i & freg_i;
            upd_zero_o = 1'b1;
         end
         `CAX_OP_ADD_ACC_REG: begin
            upd_carry_o = 1'b1;
            upd_nibble_o = 1'b1;
            upd_zero_o = 1'b1;
         end
         `CAX_OP_ADD_ACC_REG_WITH_CARRY: begin
            add_cin = carry_i;
            upd_carry_o = 1'b1;
            upd_nibble_o = 1'b1;
            upd_zero_o = 1'b1;
         end
         `CAX_OP_ARITH_SHIFT_RIGHT: begin
            result_o = {freg_i[7], freg_i[7:1]};
            carry_o = freg_i[0];
            upd_carry_o = 1'b1;
            upd_zero_o = 1'b1;
         end
         `CAX_OP_BIT_CLEAR_REG: begin
            result_o = freg_i & ~(8'h01 << bit_sel_i);
         end
         default: begin
            result_o = acc_i;
         end
      endcase
      sum = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_cin};
      low_sum = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
      if (upd_nibble_o) begin
         result_o = sum[7:0];
         carry_o = sum[8];
      end
      nibble_carry_o = low_sum[4];
      zero_o = (result_o == 8'h00);
   end

endmodule // cax_alu
`default_nettype wire

//--- rtl/cax_execute_slice.v
// Execution slice of the CPU core: accumulator, status flags, two indirect
// pointers and a 128-byte file register array, with an APB slave port.
// Assumes the decoder offers one operation per exec_valid_i and waits for
// exec_ready_o; APB transfers follow the usual setup/access sequence.
//
// Summary of operation
// - Pointer op adds signed 6-bit literal to pointer 0 or 1, flags untouched.
// - Pointer result wraps modulo the range 0000h to FFFh.
// - AND literal with accumulator, result to accumulator, zero flag only.
// - Add literal to accumulator, result to accumulator, carry, nibble, zero.
// - Destination 0 writes accumulator, 1 writes the file register 0..127.
// - AND accumulator with file register to destination, zero flag only.
// - Add accumulator and file register to destination, carry, nibble, zero.
// - Add accumulator, file register and carry to destination, all three.
// - Shift file register right keeping bit 7, bit 0 to carry, zero.
// - Bit clear forces selected bit 0..7 of file register low, no flags.
`timescale 1ns/1ps
`default_nettype none
`include "cax_defines.vh"

module cax_execute_slice (
   input wire clock_i,
   input wire reset_n_i,
   // APB slave.
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [`CAX_ADDR_W-1:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [3:0] pstrb_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   // Decoded operation from the sequencer.
   input wire exec_valid_i,
   input wire [`CAX_OP_W-1:0] exec_op_i,
   input wire [7:0] exec_literal_i,
   input wire [`CAX_FADDR_W-1:0] exec_faddr_i,
   input wire exec_dest_i,
   input wire [2:0] exec_bit_sel_i,
   input wire exec_ptr_sel_i,
   output reg exec_ready_o,
   output reg exec_done_o,
   // Architectural state seen by the rest of the core.
   output reg [7:0] acc_o,
   output reg carry_o,
   output reg nibble_carry_o,
   output reg zero_o,
   output reg [`CAX_PTR_W-1:0] ptr0_o,
   output reg [`CAX_PTR_W-1:0] ptr1_o
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   reg [7:0] file_r [0:`CAX_FILE_DEPTH-1];
   reg [15:0] exec_count_r;

   wire exec_take;
   wire apb_take;
   wire apb_wr;
   wire file_hit;
   wire [`CAX_FADDR_W-1:0] apb_faddr;
   wire [7:0] freg;
   wire [7:0] alu_result;
   wire alu_carry;
   wire alu_nibble;
   wire alu_zero;
   wire upd_carry;
   wire upd_nibble;
   wire upd_zero;
   wire is_ptr_op;
   wire to_file;
   wire to_acc;
   wire [`CAX_PTR_W-1:0] ptr_sel_val;
   wire [`CAX_PTR_W-1:0] ptr_sum;
   wire [`CAX_PTR_W-1:0] ptr_next;
   wire [`CAX_PTR_W-1:0] lit_ext;
   wire [7:0] wr_byte;

   // The decoder is held off from the cycle after psel_i rises until the cycle
   // after it falls, so bus writes and executed operations never land on the same edge.
   assign exec_take = exec_valid_i & exec_ready_o;
   assign apb_take = psel_i & penable_i & pready_o;
   assign apb_wr = apb_take & pwrite_i & pstrb_i[0];
   assign file_hit = (paddr_i[`CAX_ADDR_W-1:9] == `CAX_FILE_BASE_HI);
   assign apb_faddr = paddr_i[8:2];
   assign wr_byte = pwdata_i[7:0];
   assign freg = file_r[exec_faddr_i];

   // ----------------------------------------------------------------------
   // Byte ALU
   // ----------------------------------------------------------------------
   cax_alu u_alu (
      .op_i(exec_op_i),
      .acc_i(acc_o),
      .freg_i(freg),
      .literal_i(exec_literal_i),
      .carry_i(carry_o),
      .bit_sel_i(exec_bit_sel_i),
      .result_o(alu_result),
      .carry_o(alu_carry),
      .nibble_carry_o(alu_nibble),
      .zero_o(alu_zero),
      .upd_carry_o(upd_carry),
      .upd_nibble_o(upd_nibble),
      .upd_zero_o(upd_zero)
   );

   // ----------------------------------------------------------------------
   // Destination routing
   // ----------------------------------------------------------------------
   assign is_ptr_op = (exec_op_i == `CAX_OP_ADD_LITERAL_TO_POINTER);
   // Literal forms always land in the accumulator; bit clear always in f.
   assign to_file = exec_take & ~is_ptr_op &
      (exec_op_i != `CAX_OP_AND_IMM_ACC) &
      (exec_op_i != `CAX_OP_ADD_IMM_ACC) &
      ((exec_op_i == `CAX_OP_BIT_CLEAR_REG) |
       (exec_dest_i == `CAX_DEST_FILE));
   assign to_acc = exec_take & ~is_ptr_op & ~to_file;

   // ----------------------------------------------------------------------
   // Indirect pointer arithmetic
   // ----------------------------------------------------------------------
   assign lit_ext = {{(`CAX_PTR_W-`CAX_LIT6_W){exec_literal_i[5]}},
      exec_literal_i[`CAX_LIT6_W-1:0]};
   assign ptr_sel_val = exec_ptr_sel_i ? ptr1_o : ptr0_o;
   assign ptr_sum = ptr_sel_val + lit_ext;
   assign ptr_next = ptr_sum & `CAX_PTR_MASK;

   // ----------------------------------------------------------------------
   // Accumulator, flags and pointers
   // ----------------------------------------------------------------------
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         acc_o <= `CAX_ACC_RST;
         carry_o <= 1'b0;
         nibble_carry_o <= 1'b0;
         zero_o <= 1'b0;
         ptr0_o <= `CAX_PTR_RST;
         ptr1_o <= `CAX_PTR_RST;
      end else if (exec_take) begin
         if (to_acc) begin
            acc_o <= alu_result;
         end
         if (upd_carry) begin
            carry_o <= alu_carry;
         end
         if (upd_nibble) begin
            nibble_carry_o <= alu_nibble;
         end
         if (upd_zero) begin
            zero_o <= alu_zero;
         end
         if (is_ptr_op && !exec_ptr_sel_i) begin
            ptr0_o <= ptr_next;
         end
         if (is_ptr_op && exec_ptr_sel_i) begin
            ptr1_o <= ptr_next;
         end
      end else if (apb_wr) begin
         case (paddr_i)
            `CAX_REG_ACC: begin
               acc_o <= wr_byte;
            end
            `CAX_REG_STATUS: begin
               carry_o <= wr_byte[`CAX_ST_CARRY];
               nibble_carry_o <= wr_byte[`CAX_ST_NIBBLE_CARRY];
               zero_o <= wr_byte[`CAX_ST_ZERO];
            end
            `CAX_REG_PTR0: begin
               if (pstrb_i[1]) begin
                  ptr0_o <= pwdata_i[15:0] & `CAX_PTR_MASK;
               end else begin
                  ptr0_o <= {ptr0_o[15:8], wr_byte} & `CAX_PTR_MASK;
               end
            end
            `CAX_REG_PTR1: begin
               if (pstrb_i[1]) begin
                  ptr1_o <= pwdata_i[15:0] & `CAX_PTR_MASK;
               end else begin
                  ptr1_o <= {ptr1_o[15:8], wr_byte} & `CAX_PTR_MASK;
               end
            end
            default: begin
               acc_o <= acc_o;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // File register array, one entry per generate step
   // ----------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `CAX_FILE_DEPTH; gi = gi + 1) begin : g_file
         always @(posedge clock_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               file_r[gi] <= 8'h00;
            end else if (to_file && exec_faddr_i == gi) begin
               file_r[gi] <= alu_result;
            end else if (apb_wr && file_hit && apb_faddr == gi) begin
               file_r[gi] <= wr_byte;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Sequencer handshake
   // ----------------------------------------------------------------------
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         exec_ready_o <= 1'b0;
         exec_done_o <= 1'b0;
         exec_count_r <= 16'h0000;
      end else begin
         exec_ready_o <= ~psel_i;
         exec_done_o <= exec_take;
         if (exec_take) begin
            exec_count_r <= exec_count_r + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------------
   // APB slave: one wait state, answer in the second access cycle
   // ----------------------------------------------------------------------
   reg [31:0] rd_nxt;
   reg err_nxt;

   always @* begin
      rd_nxt = 32'h0000_0000;
      err_nxt = 1'b0;
      if (file_hit) begin
         rd_nxt = {24'h000000, file_r[apb_faddr]};
      end else begin
         case (paddr_i)
            `CAX_REG_ACC: begin
               rd_nxt = {24'h000000, acc_o};
            end
            `CAX_REG_STATUS: begin
               rd_nxt = {29'h0000000, zero_o, nibble_carry_o, carry_o};
            end
            `CAX_REG_PTR0: begin
               rd_nxt = {16'h0000, ptr0_o};
            end
            `CAX_REG_PTR1: begin
               rd_nxt = {16'h0000, ptr1_o};
            end
            `CAX_REG_EXEC_COUNT: begin
               rd_nxt = {16'h0000, exec_count_r};
               err_nxt = pwrite_i;
            end
            default: begin
               err_nxt = 1'b1;
            end
         endcase
      end
   end

   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else if (psel_i && penable_i && !pready_o) begin
         pready_o <= 1'b1;
         prdata_o <= pwrite_i ? 32'h0000_0000 : rd_nxt;
         pslverr_o <= err_nxt;
      end else begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end
   end

endmodule // cax_execute_slice
`default_nettype wire

//--- verif/cax_checker.sv
// Concurrent checks on the execution slice ports: results, flags, handshake.
// Assumes it is bound to cax_execute_slice and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module cax_checker (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic exec_valid_i,
   input wire logic [2:0] exec_op_i,
   input wire logic [7:0] exec_literal_i,
   input wire logic exec_dest_i,
   input wire logic exec_ptr_sel_i,
   input wire logic exec_ready_o,
   input wire logic exec_done_o,
   input wire logic [7:0] acc_o,
   input wire logic carry_o,
   input wire logic nibble_carry_o,
   input wire logic zero_o,
   input wire logic [15:0] ptr0_o,
   input wire logic [15:0] ptr1_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!reset_n_i);
   wire tk = exec_valid_i && exec_ready_o;
   wire [15:0] kx = {{10{exec_literal_i[5]}}, exec_literal_i[5:0]};
   wire [2:0] fl = {carry_o, nibble_carry_o, zero_o};

   property p_ptr_flags;
      tk && exec_op_i == 3'h0 |=> $stable(fl);
   endproperty
   a_ptr_flags: assert property (p_ptr_flags)
      else $error("flags moved on pointer add");
   property p_ptr_sum;
      tk && exec_op_i == 3'h0 && !exec_ptr_sel_i
         |=> ptr0_o == (($past(ptr0_o) + $past(kx)) & 16'h0fff);
   endproperty
   a_ptr_sum: assert property (p_ptr_sum)
      else $error("pointer 0 sum wrong");
   property p_ptr_range;
      ptr0_o[15:12] == 4'h0 && ptr1_o[15:12] == 4'h0;
   endproperty
   a_ptr_range: assert property (p_ptr_range)
      else $error("pointer above 12 bits");
   property p_and_imm;
      tk && exec_op_i == 3'h1 |=> acc_o == ($past(acc_o) &
         $past(exec_literal_i)) && carry_o == $past(carry_o);
   endproperty
   a_and_imm: assert property (p_and_imm)
      else $error("and literal result wrong");
   property p_add_imm;
      tk && exec_op_i == 3'h2
         |=> {carry_o, acc_o} == $past(acc_o) + $past(exec_literal_i);
   endproperty
   a_add_imm: assert property (p_add_imm)
      else $error("add literal result wrong");
   property p_flags_imm;
      tk && exec_op_i == 3'h2 |=> zero_o == (acc_o == 8'h00) &&
         nibble_carry_o == (($past(acc_o[3:0]) +
         $past(exec_literal_i[3:0])) > 5'h0f);
   endproperty
   a_flags_imm: assert property (p_flags_imm)
      else $error("zero or nibble carry wrong");
   property p_dest_file;
      tk && exec_op_i >= 3'h3 && exec_op_i <= 3'h6 && exec_dest_i
         |=> $stable(acc_o);
   endproperty
   a_dest_file: assert property (p_dest_file)
      else $error("accumulator hit with file destination");
   property p_bit_clear;
      tk && exec_op_i == 3'h7 |=> $stable(fl) && $stable(acc_o);
   endproperty
   a_bit_clear: assert property (p_bit_clear)
      else $error("bit clear touched flags or accumulator");
   property p_done;
      tk |=> exec_done_o;
   endproperty
   a_done: assert property (p_done)
      else $error("no done pulse after a taken operation");
   c_ptr: cover property (tk && exec_op_i == 3'h0);
   c_shift: cover property (tk && exec_op_i == 3'h6);
   c_stall: cover property (exec_valid_i && !exec_ready_o);
endmodule // cax_checker

bind cax_execute_slice cax_checker u_chk (.clock_i(clock_i),
   .reset_n_i(reset_n_i), .exec_valid_i(exec_valid_i),
   .exec_op_i(exec_op_i), .exec_literal_i(exec_literal_i),
   .exec_dest_i(exec_dest_i), .exec_ptr_sel_i(exec_ptr_sel_i),
   .exec_ready_o(exec_ready_o), .exec_done_o(exec_done_o),
   .acc_o(acc_o), .carry_o(carry_o), .nibble_carry_o(nibble_carry_o),
   .zero_o(zero_o), .ptr0_o(ptr0_o), .ptr1_o(ptr1_o));
`default_nettype wire

//--- verif/cax_seq_model.sv
// Decoder and sequencer stand-in: offers one operation and holds it.
// Assumes calls start right after a rising edge of clock_i.
`timescale 1ns/1ps
`default_nettype none

module cax_seq_model (
   input wire logic clock_i,
   input wire logic exec_ready_i,
   output logic valid_o,
   output logic [2:0] op_o,
   output logic [7:0] literal_o,
   output logic [6:0] faddr_o,
   output logic dest_o,
   output logic [2:0] bit_sel_o,
   output logic ptr_sel_o
);
   initial begin
      {valid_o, op_o, literal_o, faddr_o, dest_o, bit_sel_o, ptr_sel_o} = '0;
   end
   task automatic issue(input logic [2:0] op, input logic [7:0] k,
         input logic [6:0] fa, input logic d, input logic [2:0] b,
         input logic n);
      valid_o <= 1'b1;
      {op_o, literal_o, faddr_o, dest_o, bit_sel_o, ptr_sel_o} <=
         {op, k, fa, d, b, n};
      do @(posedge clock_i); while (exec_ready_i !== 1'b1);
   endtask
   // Released operands flip so that stale values are never mistaken.
   task automatic rel;
      valid_o <= 1'b0;
      {op_o, literal_o, faddr_o, dest_o, bit_sel_o, ptr_sel_o} <=
         ~{op_o, literal_o, faddr_o, dest_o, bit_sel_o, ptr_sel_o};
   endtask
endmodule // cax_seq_model
`default_nettype wire

//--- verif/core_alu_execute_slice_tb.sv
// Self-checking bench: APB register access and operations with a model.
// Assumes the slice, the sequencer model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "cax_defines.vh"

module core_alu_execute_slice_tb;
   logic clock_i, reset_n_i, psel, penable, pwrite, rd_e;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd_v;
   logic [3:0] pstrb;
   wire [31:0] prdata;
   wire pready, pslverr, ev, erdy, edone, ed, en, c, dc, z;
   wire [2:0] eop, ebit;
   wire [7:0] elit, acc;
   wire [6:0] efa;
   wire [15:0] p0, p1;
   int n_errors = 0;
   int num_checks = 0;
   logic [7:0] m_acc, m_f [128];
   logic m_c, m_dc, m_z;
   logic [15:0] m_p [2];

   cax_execute_slice u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .exec_valid_i(ev), .exec_op_i(eop), .exec_literal_i(elit),
      .exec_faddr_i(efa), .exec_dest_i(ed), .exec_bit_sel_i(ebit),
      .exec_ptr_sel_i(en), .exec_ready_o(erdy), .exec_done_o(edone),
      .acc_o(acc), .carry_o(c), .nibble_carry_o(dc), .zero_o(z),
      .ptr0_o(p0), .ptr1_o(p1));
   cax_seq_model u_seq (.clock_i(clock_i), .exec_ready_i(erdy),
      .valid_o(ev), .op_o(eop), .literal_o(elit), .faddr_o(efa),
      .dest_o(ed), .bit_sel_o(ebit), .ptr_sel_o(en));

   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks=%0d mismatches=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, input logic [3:0] s);
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock_i);
      penable <= 1'b1;
      do @(posedge clock_i); while (pready !== 1'b1);
      rd_v = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
         input logic er);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(rd_v, e);
      chk(rd_e, er);
   endtask
   task automatic fw(input logic [6:0] fa, input logic [7:0] v);
      apb(1'b1, {`CAX_FILE_BASE_HI, fa, 2'b00}, {24'h0, v}, 4'h1);
      m_f[fa] = v;
   endtask
   // Reference behaviour of one operation on the model state.
   task automatic ref_exec(input logic [2:0] op, input logic [7:0] k,
         input logic [6:0] fa, input logic d, input logic [2:0] b);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] r;
      r = m_f[fa];
      s = 9'h0;
      h = 5'h0;
      case (op)
         3'h0: m_p[b[0]] = (m_p[b[0]] + {{10{k[5]}}, k[5:0]}) & 16'h0fff;
         3'h1: begin
            r = m_acc & k;
            d = 1'b0;
         end
         3'h2: begin
            s = m_acc + k;
            h = m_acc[3:0] + k[3:0];
            d = 1'b0;
         end
         3'h3: r = m_acc & m_f[fa];
         3'h4, 3'h5: begin
            s = m_acc + m_f[fa] + (op[0] & m_c);
            h = m_acc[3:0] + m_f[fa][3:0] + (op[0] & m_c);
         end
         3'h6: begin
            r = {m_f[fa][7], m_f[fa][7:1]};
            m_c = m_f[fa][0];
         end
         default: begin
            r[b] = 1'b0;
            d = 1'b1;
         end
      endcase
      if (op == 3'h2 || op[2:1] == 2'b10) begin
         r = s[7:0];
         m_c = s[8];
         m_dc = h[4];
      end
      if (op != 3'h0 && op != 3'h7)
         m_z = (r == 8'h00);
      if (op != 3'h0) begin
         if (d)
            m_f[fa] = r;
         else
            m_acc = r;
      end
   endtask
   task automatic st(input logic [6:0] fa);
      @(negedge clock_i);
      chk(acc, m_acc);
      chk({c, dc, z}, {m_c, m_dc, m_z});
      chk(p0, m_p[0]);
      chk(p1, m_p[1]);
      chk(edone, 1'b1);
      rd({`CAX_FILE_BASE_HI, fa, 2'b00}, {24'h0, m_f[fa]}, 1'b0);
   endtask
   // For the pointer add, b carries the pointer select in bit 0.
   task automatic run(input logic [2:0] op, input logic [7:0] k,
         input logic [6:0] fa, input logic d, input logic [2:0] b);
      ref_exec(op, k, fa, d, b);
      @(posedge clock_i);
      u_seq.issue(op, k, fa, d, b, b[0]);
      u_seq.rel;
      st(fa);
   endtask

   initial begin
      repeat (20000) @(posedge clock_i);
      n_errors++;
      test_done;
   end
   initial begin
      reset_n_i = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {m_acc, m_c, m_dc, m_z} = '0;
      m_p = '{16'h0, 16'h0};
      repeat (6) @(posedge clock_i);
      reset_n_i <= 1'b1;
      rd(12'h000, 32'h0, 1'b0);
      rd(12'h004, 32'h0, 1'b0);
      rd(12'h014, 32'h0, 1'b1);
      apb(1'b1, 12'h010, 32'h5, 4'hf);
      chk(rd_e, 1'b1);
      rd(12'h010, 32'h0, 1'b0);
      apb(1'b1, 12'h000, 32'hf1, 4'hf);
      apb(1'b1, 12'h000, 32'h33, 4'he);
      rd(12'h000, 32'hf1, 1'b0);
      $display("test registers done");
      apb(1'b1, 12'h004, 32'h1, 4'h1);
      apb(1'b1, 12'h008, 32'h0ffe, 4'h3);
      {m_acc, m_c, m_p[0]} = {8'hf1, 1'b1, 16'h0ffe};
      fw(7'h05, 8'h8f);
      fw(7'h7f, 8'h01);
      run(3'h0, 8'h05, 7'h05, 1'b0, 3'h0);
      run(3'h0, 8'h20, 7'h05, 1'b0, 3'h1);
      run(3'h0, 8'h1f, 7'h05, 1'b0, 3'h1);
      run(3'h1, 8'h0f, 7'h05, 1'b1, 3'h0);
      run(3'h2, 8'hff, 7'h05, 1'b1, 3'h0);
      run(3'h5, 8'h00, 7'h05, 1'b1, 3'h0);
      run(3'h6, 8'h00, 7'h7f, 1'b0, 3'h0);
      run(3'h6, 8'h00, 7'h05, 1'b1, 3'h0);
      run(3'h3, 8'h00, 7'h05, 1'b0, 3'h0);
      run(3'h7, 8'h00, 7'h05, 1'b0, 3'h7);
      run(3'h4, 8'h00, 7'h05, 1'b0, 3'h0);
      run(3'h2, 8'hc0, 7'h05, 1'b0, 3'h0);
      run(3'h4, 8'h00, 7'h05, 1'b1, 3'h0);
      fw(7'h06, 8'hff);
      for (int b = 0; b < 8; b++)
         run(3'h7, 8'h00, 7'h06, 1'b0, 3'(b));
      $display("test operations done");
      ref_exec(3'h5, 8'h00, 7'h05, 1'b0, 3'h0);
      ref_exec(3'h3, 8'h00, 7'h05, 1'b1, 3'h0);
      @(posedge clock_i);
      u_seq.issue(3'h5, 8'h00, 7'h05, 1'b0, 3'h0, 1'b0);
      u_seq.issue(3'h3, 8'h00, 7'h05, 1'b1, 3'h0, 1'b0);
      u_seq.rel;
      st(7'h05);
      ref_exec(3'h4, 8'h00, 7'h05, 1'b1, 3'h0);
      fork
         apb(1'b0, 12'h000, 32'h0, 4'h0);
         begin
            repeat (2) @(posedge clock_i);
            u_seq.issue(3'h4, 8'h00, 7'h05, 1'b1, 3'h0, 1'b0);
         end
      join
      u_seq.rel;
      chk(rd_v, {24'h0, m_acc});
      st(7'h05);
      $display("test stall done");
      apb(1'b1, 12'h00c, 32'h0000_ab12, 4'h1);
      m_p[1] = {m_p[1][15:8], 8'h12} & 16'h0fff;
      rd(12'h00c, {16'h0, m_p[1]}, 1'b0);
      apb(1'b1, 12'h008, 32'h0000_ffff, 4'h3);
      rd(12'h008, 32'h0000_0fff, 1'b0);
      rd(12'h004, {29'h0, m_z, m_dc, m_c}, 1'b0);
      rd(12'h010, 32'h0000_0018, 1'b0);
      $display("test pointer and count done");
      // A second reset in mid-run must bring every state output back.
      reset_n_i <= 1'b0;
      @(posedge clock_i);
      reset_n_i <= 1'b1;
      @(negedge clock_i);
      chk({acc, c, dc, z, erdy}, 32'h0);
      chk({p0, p1}, 32'h0);
      rd(12'h010, 32'h0, 1'b0);
      rd(12'h000, 32'h0, 1'b0);
      $display("test reset done");
      test_done;
   end
endmodule // core_alu_execute_slice_tb
`default_nettype wire
